// *** afs_top.sv ***
/*
 * Converter event flag register bank with an Avalon-MM slave, per channel
 * comparison select fields, overrun mirrors and a masked sticky interrupt.
 * Assumes comparator and overrun inputs are synchronous to REF_CLK, and a
 * master that holds each request until it sees waitrequest low.
 */
// The Avalon-MM slave port was left to the implementer.
//
// Contract
// - One threshold event flag per channel; channels 7 to 11 at their own bit.
// - A flag sets on an outside or crossing result, only for the enabled type.
// - Writing one to a flag bit clears it; software clears that way.
// - Bits 12 to 23 show live overrun flags of channels 0 to 11.
// - Bit 30 is high whenever any of the twelve threshold flags is set.
`timescale 1ns/1ps
module afs_top #(
   parameter int NCH = afs_pkg::NUM_CH
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [31:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [NCH-1:0] THR_OUTSIDE,
   input wire logic [NCH-1:0] THR_CROSS,
   input wire logic [NCH-1:0] RESULT_OVERRUN,
   output logic THRESH_IRQ_SUMMARY,
   output logic IRQ
);

   localparam int SW = 2 * NCH;

   // Bus state and registers
   afs_pkg::afs_bus_state_e state_reg;
   afs_pkg::afs_bus_state_e state_next;
   logic wait_reg;
   logic wait_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [SW-1:0] irq_enable_reg;
   logic [SW-1:0] irq_enable_next;
   logic [SW-1:0] status_reg;
   logic [SW-1:0] status_next;
   logic [SW-1:0] mask_reg;
   logic [SW-1:0] mask_next;
   logic [NCH-1:0] ovr_prev_reg;
   logic [NCH-1:0] ovr_prev_next;
   logic summary_reg;
   logic irq_reg;

   // Per channel flag wires
   logic [NCH-1:0] flag_q;
   logic [NCH-1:0] flag_nx;
   logic [NCH-1:0] set_evt;
   logic [NCH-1:0] flag_clr;

   // Request carrier
   afs_pkg::afs_bus_req_s req;
   assign req.rd = AVS_READ;
   assign req.wr = AVS_WRITE;
   assign req.addr = AVS_ADDRESS;
   assign req.wdata = AVS_WRITEDATA;
   assign req.be = AVS_BYTEENABLE;

   // Address decode
   wire logic hit_flags = (req.addr == afs_pkg::FLAGS_ADDR);
   wire logic hit_enable = (req.addr == afs_pkg::ENABLE_ADDR);
   wire logic hit_status = (req.addr == afs_pkg::STATUS_ADDR);
   wire logic hit_mask = (req.addr == afs_pkg::MASK_ADDR);
   wire logic in_idle = (state_reg == afs_pkg::ST_IDLE);
   wire logic in_ack = (state_reg == afs_pkg::ST_ACK);
   wire logic any_req = req.rd || req.wr;

   // Writes and read side effects happen only at the completing edge
   wire logic wr_done = CE && in_ack && req.wr;
   wire logic rd_done = CE && in_ack && req.rd;

   // Byte enables widened to a bit mask
   wire logic [31:0] be_mask = {{8{req.be[3]}}, {8{req.be[2]}}, {8{req.be[1]}}, {8{req.be[0]}}};
   wire logic [31:0] wr_bits = req.wdata & be_mask;

   // Read words; bits 24 to 29 and 31 of the flag word read zero
   wire logic any_flag = |flag_q;
   wire logic [31:0] flags_word = {1'b0, any_flag, 6'h00, RESULT_OVERRUN, flag_q};
   wire logic [31:0] enable_word = {5'h00, irq_enable_reg, 3'h0};
   wire logic [31:0] status_word = {8'h00, status_reg};
   wire logic [31:0] mask_word = {8'h00, mask_reg};

   // Read multiplexer; unmapped addresses read zero
   wire logic [31:0] rd_mux = hit_flags ? flags_word :
                              hit_enable ? enable_word :
                              hit_status ? status_word :
                              hit_mask ? mask_word : afs_pkg::RDATA_RST;

   // Handshake: one wait cycle, then one cycle with waitrequest low
   always_comb begin
      state_next = state_reg;
      wait_next = wait_reg;
      rdata_next = rdata_reg;
      if (CE) begin
         unique case (state_reg)
            afs_pkg::ST_IDLE: begin
               if (any_req) begin
                  state_next = afs_pkg::ST_ACK;
                  wait_next = 1'b0;
                  rdata_next = req.rd ? rd_mux : afs_pkg::RDATA_RST;
               end
            end
            afs_pkg::ST_ACK: begin
               state_next = afs_pkg::ST_IDLE;
               wait_next = 1'b1;
            end
         endcase
      end
   end

   // Bus state registers
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state_reg <= afs_pkg::ST_IDLE;
         wait_reg <= 1'b1;
         rdata_reg <= afs_pkg::RDATA_RST;
      end else begin
         state_reg <= state_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   // Clear strobes: ones only, zeros and mirror bits have no effect
   assign flag_clr = (wr_done && hit_flags) ? wr_bits[NCH-1:0] : {NCH{1'b0}};

   // One flag cell per channel
   generate
      for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
         afs_flag_cell u_cell (
            .clk(REF_CLK),
            .rst(RST),
            .ce(CE),
            .sel(irq_enable_reg[SEL_PAIR(ch) +: 2]),
            .outside(THR_OUTSIDE[ch]),
            .crossing(THR_CROSS[ch]),
            .clr(flag_clr[ch]),
            .flag(flag_q[ch]),
            .flag_nx(flag_nx[ch]),
            .set_evt(set_evt[ch])
         );
      end
   endgenerate

   // Position of a channel's select field
   function automatic int SEL_PAIR(input int ch);
      SEL_PAIR = afs_pkg::SEL_W * ch;
   endfunction

   // Select fields: software writable per byte lane
   wire logic [SW-1:0] en_lane = be_mask[afs_pkg::SEL_LSB +: SW];
   wire logic [SW-1:0] en_data = req.wdata[afs_pkg::SEL_LSB +: SW];
   assign irq_enable_next = (wr_done && hit_enable) ?
                            ((irq_enable_reg & ~en_lane) | (en_data & en_lane)) :
                            irq_enable_reg;

   // Mask register, same layout as the status register
   wire logic [SW-1:0] mask_lane = be_mask[SW-1:0];
   assign mask_next = (wr_done && hit_mask) ?
                      ((mask_reg & ~mask_lane) | (req.wdata[SW-1:0] & mask_lane)) :
                      mask_reg;

   // Sticky events: threshold sets and overrun rising edges
   wire logic [NCH-1:0] ovr_rise = RESULT_OVERRUN & ~ovr_prev_reg;
   wire logic [SW-1:0] evt = CE ? {ovr_rise, set_evt} : {SW{1'b0}};
   // Clear only what the read returned, so a later event is never lost
   wire logic [SW-1:0] rd_clear = (rd_done && hit_status) ? rdata_reg[SW-1:0] : {SW{1'b0}};
   assign status_next = (status_reg & ~rd_clear) | evt;
   assign ovr_prev_next = CE ? RESULT_OVERRUN : ovr_prev_reg;

   // Software registers and edge history
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         irq_enable_reg <= afs_pkg::ENABLE_RST;
         mask_reg <= afs_pkg::MASK_RST;
         status_reg <= afs_pkg::STATUS_RST;
         ovr_prev_reg <= {NCH{1'b0}};
      end else begin
         irq_enable_reg <= irq_enable_next;
         mask_reg <= mask_next;
         status_reg <= status_next;
         ovr_prev_reg <= ovr_prev_next;
      end
   end

   // Outputs computed from next values so they track the flags exactly
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         summary_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         summary_reg <= |flag_nx;
         irq_reg <= |(status_next & mask_next);
      end
   end

   assign AVS_READDATA = rdata_reg;
   assign AVS_WAITREQUEST = wait_reg;
   assign THRESH_IRQ_SUMMARY = summary_reg;
   assign IRQ = irq_reg;

   // Checks on the flag word as software sees it
   // First completion cycle only; check helper, so it is not frozen by CE
   logic ack_new_reg;
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ack_new_reg <= 1'b0;
      end else begin
         ack_new_reg <= CE && in_idle && any_req;
      end
   end
   wire logic ack_flags_rd = ack_new_reg && req.rd && hit_flags;

   AST_SUMMARY_TRACKS: assert property (@(posedge REF_CLK) disable iff (RST)
      THRESH_IRQ_SUMMARY == (|flag_q))
      else $error("summary output differs from flags");

   AST_SUM_BIT_READ: assert property (@(posedge REF_CLK) disable iff (RST)
      ack_flags_rd |-> AVS_READDATA[afs_pkg::SUM_BIT] == $past(any_flag))
      else $error("bit 30 does not match any flag");

   AST_FLAG_POSITION: assert property (@(posedge REF_CLK) disable iff (RST)
      ack_flags_rd |-> AVS_READDATA[11:0] == $past(flag_q))
      else $error("channel flags 7 to 11 misplaced");

   AST_OVR_MIRROR: assert property (@(posedge REF_CLK) disable iff (RST)
      ack_flags_rd |-> AVS_READDATA[23:12] == $past(RESULT_OVERRUN))
      else $error("overrun mirror not live");

   AST_ZERO_WRITE_KEEPS: assert property (@(posedge REF_CLK) disable iff (RST)
      wr_done && hit_flags && (wr_bits[NCH-1:0] == 12'h000) |=> flag_q == ($past(flag_q) | $past(set_evt)))
      else $error("write of zeros changed a flag");

   AST_CLEAR_WRITE: assert property (@(posedge REF_CLK) disable iff (RST)
      wr_done && hit_flags && wr_bits[7] && !set_evt[7] |=> !flag_q[7])
      else $error("write of one left flag 7 set");

   AST_ONE_ACK_CYCLE: assert property (@(posedge REF_CLK) disable iff (RST)
      !AVS_WAITREQUEST && CE |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");

   AST_IRQ_MASKED: assert property (@(posedge REF_CLK) disable iff (RST)
      IRQ == (|(status_reg & mask_reg)))
      else $error("interrupt output differs from masked status");

   // Handshake shape: idle always waits, a taken request is answered next cycle
   AST_IDLE_WAITS: assert property (@(posedge REF_CLK) disable iff (RST)
      in_idle |-> AVS_WAITREQUEST)
      else $error("waitrequest low while slave idle");

   AST_TAKE_ANSWERS: assert property (@(posedge REF_CLK) disable iff (RST)
      CE && in_idle && any_req |=> !AVS_WAITREQUEST)
      else $error("request not answered after one wait cycle");

   // Reserved bits, unmapped reads and writes return zero data
   AST_RESERVED_READ_ZERO: assert property (@(posedge REF_CLK) disable iff (RST)
      ack_flags_rd |-> (AVS_READDATA[31] == 1'b0) && (AVS_READDATA[29:24] == 6'h00))
      else $error("reserved flag bits read nonzero");

   AST_UNMAPPED_READ_ZERO: assert property (@(posedge REF_CLK) disable iff (RST)
      ack_new_reg && req.rd && !(hit_flags || hit_enable || hit_status || hit_mask) |-> AVS_READDATA == 32'h00000000)
      else $error("unmapped read returned data");

   AST_WRITE_LOADS_ZERO: assert property (@(posedge REF_CLK) disable iff (RST)
      ack_new_reg && req.wr |-> AVS_READDATA == 32'h00000000)
      else $error("write completion left read data");

   // Clock enable low holds every register except the ack_new_reg check helper
   AST_FREEZE_FLAGS: assert property (@(posedge REF_CLK) disable iff (RST)
      !CE |=> flag_q == $past(flag_q))
      else $error("flags changed while clock enable low");

   AST_FREEZE_REGS: assert property (@(posedge REF_CLK) disable iff (RST)
      !CE |=> (status_reg == $past(status_reg)) && (mask_reg == $past(mask_reg)) &&
              (irq_enable_reg == $past(irq_enable_reg)))
      else $error("registers changed while clock enable low");

   // Status capture and read clear, set winning the same edge
   AST_STATUS_CATCHES: assert property (@(posedge REF_CLK) disable iff (RST)
      |set_evt |=> (status_reg[NCH-1:0] & $past(set_evt)) == $past(set_evt))
      else $error("threshold event missing from status");

   AST_READ_CLEARS: assert property (@(posedge REF_CLK) disable iff (RST)
      rd_done && hit_status |=> (status_reg & $past(rd_clear) & ~$past(evt)) == {SW{1'b0}})
      else $error("status read did not clear returned bits");

   // Full word write of the select fields
   AST_SELECT_WRITE: assert property (@(posedge REF_CLK) disable iff (RST)
      wr_done && hit_enable && (req.be == 4'hF) |=> irq_enable_reg == $past(en_data))
      else $error("select field write not stored");

endmodule // afs_top

// *** afs_pkg.sv ***
/*
 * Package for the converter event flag block: register byte addresses,
 * field positions, reset values, select codes, bus request carrier and
 * the bus handshake states.
 * Assumes a 32-bit Avalon-MM byte address and twelve analog channels.
 */
package afs_pkg;

   // Channel count and field widths
   localparam int NUM_CH = 12;
   localparam int SEL_W = 2;
   localparam int STAT_W = 2 * NUM_CH;

   // Register byte addresses
   localparam logic [31:0] FLAGS_ADDR = 32'h4001C068;
   localparam logic [31:0] ENABLE_ADDR = 32'h4001C064;
   localparam logic [31:0] STATUS_ADDR = 32'h4001C070;
   localparam logic [31:0] MASK_ADDR = 32'h4001C074;

   // Field positions in the flag word
   localparam int THR_LSB = 0;
   localparam int OVR_LSB = 12;
   localparam int SUM_BIT = 30;

   // Field position of the select fields in the enable word
   localparam int SEL_LSB = 3;

   // Comparison select codes; 2'h3 is reserved and sets nothing
   localparam logic [1:0] SEL_OFF = 2'h0;
   localparam logic [1:0] SEL_OUTSIDE = 2'h1;
   localparam logic [1:0] SEL_CROSS = 2'h2;

   // Values after reset
   localparam logic [STAT_W-1:0] ENABLE_RST = 24'h000000;
   localparam logic [STAT_W-1:0] STATUS_RST = 24'h000000;
   localparam logic [STAT_W-1:0] MASK_RST = 24'h000000;
   localparam logic [31:0] RDATA_RST = 32'h00000000;

   // One bus request as the slave sees it
   typedef struct packed {
      logic rd;
      logic wr;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } afs_bus_req_s;

   // Bus handshake states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACK = 2'b10
   } afs_bus_state_e;

endpackage

// *** afs_flag_cell.sv ***
/*
 * One threshold event flag: set by the selected comparison event,
 * cleared by a write of one, with the set winning a same-cycle clear.
 * Assumes event inputs are one-cycle pulses synchronous to the clock.
 */
`timescale 1ns/1ps
module afs_flag_cell (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [1:0] sel,
   input wire logic outside,
   input wire logic crossing,
   input wire logic clr,
   output logic flag,
   output logic flag_nx,
   output logic set_evt
);

   logic flag_reg;
   logic flag_next;
   wire logic hit_outside = (sel == afs_pkg::SEL_OUTSIDE) && outside;
   wire logic hit_cross = (sel == afs_pkg::SEL_CROSS) && crossing;

   // Only the enabled comparison type counts; reserved code sets nothing
   assign set_evt = ce && (hit_outside || hit_cross);
   // Set beats clear so an event in the clearing cycle is kept
   assign flag_next = !ce ? flag_reg : (set_evt || (flag_reg && !clr));
   assign flag = flag_reg;
   assign flag_nx = flag_next;

   // Flag storage
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   AST_SET_ON_EVENT: assert property (@(posedge clk) disable iff (rst)
      (ce && hit_outside) || (ce && hit_cross) |=> flag_reg)
      else $error("flag not set by enabled event");

   AST_NO_SET_WHEN_OFF: assert property (@(posedge clk) disable iff (rst)
      (sel == afs_pkg::SEL_OFF) && !flag_reg |=> !flag_reg)
      else $error("flag set while comparison disabled");

   AST_CLEAR_BY_ONE: assert property (@(posedge clk) disable iff (rst)
      ce && clr && !set_evt |=> !flag_reg)
      else $error("write of one did not clear flag");

   AST_HOLD_NO_CLEAR: assert property (@(posedge clk) disable iff (rst)
      flag_reg && !(ce && clr) |=> flag_reg)
      else $error("flag lost without a clearing write");

endmodule // afs_flag_cell

// *** afs_top_tb.sv ***
/*
 * Self-checking bench for the converter event flag bank: Avalon-MM
 * read and write tasks, then tests built from sequences of bus calls.
 * Assumes the afs_top ports and package layout; CE drops only while idle.
 */
`timescale 1ns/1ps
module afs_top_tb;
   logic REF_CLK = 1'b0;
   logic RST = 1'b1;
   logic CE = 1'b1;
   logic [31:0] AVS_ADDRESS = 32'h00000000;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h00000000;
   logic [3:0] AVS_BYTEENABLE = 4'hF;
   logic [11:0] THR_OUTSIDE = 12'h000;
   logic [11:0] THR_CROSS = 12'h000;
   logic [11:0] RESULT_OVERRUN = 12'h000;
   wire [31:0] AVS_READDATA;
   wire AVS_WAITREQUEST;
   wire THRESH_IRQ_SUMMARY;
   wire IRQ;
   int bad_count = 0;
   int tests_run = 0;
   logic [31:0] rd;
   logic [31:0] enw;
   logic [1:0] sel_tab [12] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};

   // Clock enable is lowered only between transfers, never mid-access
   afs_top DUT (.REF_CLK(REF_CLK), .RST(RST), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .THR_OUTSIDE(THR_OUTSIDE),
      .THR_CROSS(THR_CROSS), .RESULT_OVERRUN(RESULT_OVERRUN), .THRESH_IRQ_SUMMARY(THRESH_IRQ_SUMMARY), .IRQ(IRQ));

   // 20 MHz clock
   initial begin
      forever #25 REF_CLK = ~REF_CLK;
   end

   // Verdict and end of run
   task automatic test_done();
      $display("Counts: %0d compared, %0d mismatched", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Waits for waitrequest low; a hung slave ends the run
   task automatic wait_ack();
      int n;
      for (n = 0; n < 20; n++) begin
         @(posedge REF_CLK);
         if (AVS_WAITREQUEST === 1'b0) break;
      end
      if (n == 20) begin
         bad_count++;
         $display("CHECK FAILED waitrequest expected 0 seen stuck");
         test_done();
      end
   endtask

   task automatic bus_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge REF_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_BYTEENABLE <= be;
      AVS_WRITE <= 1'b1;
      wait_ack();
      AVS_WRITE <= 1'b0;
   endtask

   task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
      @(posedge REF_CLK);
      AVS_ADDRESS <= a;
      AVS_BYTEENABLE <= 4'hF;
      AVS_READ <= 1'b1;
      wait_ack();
      d = AVS_READDATA;
      AVS_READ <= 1'b0;
   endtask

   task automatic read_check(input string what, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus_read(a, v);
      check(what, exp, v);
   endtask

   // One-cycle comparator result pulses
   task automatic pulse(input logic [11:0] o, input logic [11:0] c);
      @(posedge REF_CLK);
      THR_OUTSIDE <= o;
      THR_CROSS <= c;
      @(posedge REF_CLK);
      THR_OUTSIDE <= 12'h000;
      THR_CROSS <= 12'h000;
   endtask

   // Flags expected from the select table for given pulses
   function automatic logic [31:0] exp_flags(input logic [11:0] o, input logic [11:0] c);
      logic [31:0] f;
      f = 32'h00000000;
      for (int k = 0; k < 12; k++) begin
         if ((o[k] && sel_tab[k] == 2'h1) || (c[k] && sel_tab[k] == 2'h2)) f[k] = 1'b1;
      end
      if (f[11:0] != 12'h000) f[30] = 1'b1;
      return f;
   endfunction

   initial begin
      enw = 32'h00000000;
      for (int k = 0; k < 12; k++) enw = enw | ({30'h0, sel_tab[k]} << (2 * k + 3));
      repeat (10) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      check("waitrequest idle", 32'h1, {31'h0, AVS_WAITREQUEST});
      read_check("flags reset", afs_pkg::FLAGS_ADDR, 32'h00000000);
      read_check("enable reset", afs_pkg::ENABLE_ADDR, 32'h00000000);
      read_check("mask reset", afs_pkg::MASK_ADDR, 32'h00000000);
      read_check("unmapped", 32'h4001C0F0, 32'h00000000);
      $display("Test reset values done");

      // Every select code, including the reserved one
      bus_write(afs_pkg::ENABLE_ADDR, 32'hFFFFFFFF, 4'hF);
      read_check("enable all ones", afs_pkg::ENABLE_ADDR, 32'h07FFFFF8);
      bus_write(afs_pkg::ENABLE_ADDR, enw, 4'hF);
      read_check("enable table", afs_pkg::ENABLE_ADDR, enw);
      $display("Test select fields done");

      // Outside pulses on all channels set only outside-selected flags
      pulse(12'hFFF, 12'h000);
      read_check("flags outside", afs_pkg::FLAGS_ADDR, exp_flags(12'hFFF, 12'h000));
      check("summary port", 32'h1, {31'h0, THRESH_IRQ_SUMMARY});
      // Byte lane 0 only: channel 11 survives the clear
      bus_write(afs_pkg::FLAGS_ADDR, 32'hFFFFFFFF, 4'h1);
      read_check("flags lane clear", afs_pkg::FLAGS_ADDR, 32'h40000800);
      bus_write(afs_pkg::FLAGS_ADDR, 32'h00000000, 4'hF);
      read_check("flags write zero", afs_pkg::FLAGS_ADDR, 32'h40000800);
      bus_write(afs_pkg::FLAGS_ADDR, 32'h00000800, 4'hF);
      read_check("flags cleared", afs_pkg::FLAGS_ADDR, 32'h00000000);
      check("summary low", 32'h0, {31'h0, THRESH_IRQ_SUMMARY});
      pulse(12'h000, 12'hFFF);
      read_check("flags crossing", afs_pkg::FLAGS_ADDR, exp_flags(12'h000, 12'hFFF));
      bus_write(afs_pkg::FLAGS_ADDR, 32'h00000FFF, 4'hF);
      $display("Test threshold flags done");

      // Live overrun copies, unaffected by writes
      RESULT_OVERRUN <= 12'hA5C;
      read_check("overrun mirror", afs_pkg::FLAGS_ADDR, 32'h00A5C000);
      bus_write(afs_pkg::FLAGS_ADDR, 32'hFFFFF000, 4'hF);
      read_check("overrun after write", afs_pkg::FLAGS_ADDR, 32'h00A5C000);
      RESULT_OVERRUN <= 12'h000;
      read_check("overrun live", afs_pkg::FLAGS_ADDR, 32'h00000000);
      $display("Test overrun mirror done");

      // Sticky status, mask and read-clear
      read_check("status sticky", afs_pkg::STATUS_ADDR, 32'h00A5C983);
      bus_write(afs_pkg::MASK_ADDR, 32'h00000080, 4'hF);
      read_check("mask readback", afs_pkg::MASK_ADDR, 32'h00000080);
      read_check("status cleared", afs_pkg::STATUS_ADDR, 32'h00000000);
      pulse(12'h800, 12'h000);
      repeat (3) @(posedge REF_CLK);
      check("irq masked", 32'h0, {31'h0, IRQ});
      pulse(12'h080, 12'h000);
      repeat (3) @(posedge REF_CLK);
      check("irq raised", 32'h1, {31'h0, IRQ});
      read_check("status events", afs_pkg::STATUS_ADDR, 32'h00000880);
      repeat (3) @(posedge REF_CLK);
      check("irq after clear", 32'h0, {31'h0, IRQ});
      $display("Test interrupt done");

      // Clock enable low: pulses are ignored, flags and status hold
      @(posedge REF_CLK);
      CE <= 1'b0;
      pulse(12'h002, 12'h101);
      @(posedge REF_CLK);
      CE <= 1'b1;
      read_check("flags frozen", afs_pkg::FLAGS_ADDR, 32'h40000880);
      read_check("status frozen", afs_pkg::STATUS_ADDR, 32'h00000000);
      pulse(12'h002, 12'h000);
      read_check("flags resumed", afs_pkg::FLAGS_ADDR, 32'h40000882);
      $display("Test clock enable done");
      test_done();
   end
endmodule // afs_top_tb
